// ==== addr_buf_regs.svh ====
`ifndef ADDR_BUF_REGS_SVH
`define ADDR_BUF_REGS_SVH

// processor address width, bits 1..16
`define CPU_ADDR_W 16
// system address width, bits 0..16
`define SYS_ADDR_W 17
// dram address width
`define DRAM_ADDR_W 8
// refresh counter width
`define RFSH_W 9
// refresh counter reset value
`define RFSH_RESET 9'h000
// dram half width
`define DRAM_HALF 8

`endif

// ==== addr_buf_pkg.sv ====
package addr_buf_pkg;
	// bus ownership decoded from the control inputs
	typedef enum logic [3:0] {
		own_cpu = 4'b0001,
		own_dma = 4'b0010,
		own_rfsh = 4'b0100,
		own_hold = 4'b1000
	} owner_type;
endpackage

// ==== addr_buf_if.sv ====
`timescale 1ns/100ps
`include "addr_buf_regs.svh"
interface addr_buf_if;
	// processor side inputs
	logic [`CPU_ADDR_W-1:0] cpu_addr;
	logic cpu_upper_byte_n;
	logic addr_latch_en;
	logic dram_row_latch_en;
	logic hold_ack;
	logic dma_addr_en_n;
	logic rfsh_cycle_n;
	logic refresh_enable_n;
	logic row_col_select;
	// system bus, three signals per pin
	logic [`SYS_ADDR_W-1:0] system_addr_in;
	logic [`SYS_ADDR_W-1:0] system_addr_out;
	logic [`SYS_ADDR_W-1:0] system_addr_oe;
	logic sys_upper_byte_n_in;
	logic sys_upper_byte_n_out;
	logic sys_upper_byte_n_oe;
	// peripheral bus
	logic [`CPU_ADDR_W-1:0] periph_addr_in;
	logic [`CPU_ADDR_W-1:0] periph_addr_out;
	logic periph_addr_oe;
	logic periph_upper_byte_n_in;
	logic periph_upper_byte_n_out;
	logic periph_upper_byte_n_oe;
	// dram side
	logic [`DRAM_ADDR_W-1:0] dram_addr;
	logic refresh_count_msb;

	// documented address buffer
	modport dev (
		input cpu_addr, cpu_upper_byte_n, addr_latch_en, dram_row_latch_en, hold_ack,
		input dma_addr_en_n, rfsh_cycle_n, refresh_enable_n, row_col_select,
		input system_addr_in, sys_upper_byte_n_in, periph_addr_in, periph_upper_byte_n_in,
		output system_addr_out, system_addr_oe, sys_upper_byte_n_out, sys_upper_byte_n_oe,
		output periph_addr_out, periph_addr_oe, periph_upper_byte_n_out,
		output periph_upper_byte_n_oe, dram_addr, refresh_count_msb
	);
	// processor and system controller
	modport ctl (
		output cpu_addr, cpu_upper_byte_n, addr_latch_en, dram_row_latch_en, hold_ack,
		output dma_addr_en_n, rfsh_cycle_n, refresh_enable_n, row_col_select,
		input dram_addr, refresh_count_msb
	);
endinterface // addr_buf_if

// ==== addr_buf_dev.sv ====
`timescale 1ns/100ps
`include "addr_buf_regs.svh"
// Functional notes
// - route cpu address to three buses
// - dram latches open while row latch high
// - row latch early in fast mode, else ale
// - sys/periph latches open while ale high
// - no ale pulse during halt cycle
// - hold_ack high means cpu released bus
// - dma enable low through whole dma access
// - refresh strobe advances refresh counter
// - refresh enable low only when refresh needed
// - row_col_select picks low or high half
// - synchronous reset clears refresh counter
// - counter msb output for large drams
// - system byte-high driven only when cpu owns
// - cpu byte-high buffered to both buses
// - system bit zero driven only in refresh
// - 17 sys, 16 periph, 8 dram lines
// - counter covers both dram sizes
// - nine-bit counter, rising strobe edge
// - falling refresh enable captures counter
// - dram mux source chosen by hold_ack
// - bus directions decoded from three controls
module addr_buf_dev
	import addr_buf_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link
	addr_buf_if.dev bus
);

	////////////////////////////////////////////////////////////////
	// latches are modelled as clocked enables: inputs are synchronous
	logic [`CPU_ADDR_W-1:0] sys_latch; // sys/periph address latch
	logic [`CPU_ADDR_W-1:0] dram_latch; // dram-side address latch
	logic [`RFSH_W-1:0] rfsh_count; // free refresh counter
	logic [`RFSH_W-1:0] rfsh_hold; // captured refresh address
	logic rfsh_strobe_q; // previous strobe level
	logic rfsh_en_q; // previous refresh enable level
	logic upper_latch; // latched byte-high
	owner_type owner; // decoded bus owner
	logic [`CPU_ADDR_W-1:0] cur_sys; // transparent sys path
	logic [`CPU_ADDR_W-1:0] cur_dram; // transparent dram path
	logic [`CPU_ADDR_W-1:0] mux_src; // dram mux source
	logic [`DRAM_ADDR_W-1:0] next_dram_addr; // next dram output

	////////////////////////////////////////////////////////////////
	// address latch: follows cpu while ale high, holds when low
	always_ff @(posedge clk) begin
		if (rst) begin
			sys_latch <= '0;
			upper_latch <= 1'b1;
		end else if (bus.addr_latch_en) begin
			sys_latch <= bus.cpu_addr;
			upper_latch <= bus.cpu_upper_byte_n;
		end
	end

	// while ale is high the path is transparent, else the held value
	assign cur_sys = bus.addr_latch_en ? bus.cpu_addr : sys_latch;

	// dram latch gated by the early latch enable
	always_ff @(posedge clk) begin
		if (rst) begin
			dram_latch <= '0;
		end else if (bus.dram_row_latch_en) begin
			dram_latch <= bus.cpu_addr;
		end
	end

	// transparent while row latch enable is high
	assign cur_dram = bus.dram_row_latch_en ? bus.cpu_addr : dram_latch;

	////////////////////////////////////////////////////////////////
	// edge history for the refresh strobes
	always_ff @(posedge clk) begin
		if (rst) begin
			rfsh_strobe_q <= 1'b1;
			rfsh_en_q <= 1'b1;
		end else begin
			rfsh_strobe_q <= bus.rfsh_cycle_n;
			rfsh_en_q <= bus.refresh_enable_n;
		end
	end

	// nine bits cover both dram sizes; counts on strobe rising edge
	always_ff @(posedge clk) begin
		if (rst) begin
			rfsh_count <= `RFSH_RESET;
		end else if (bus.rfsh_cycle_n && !rfsh_strobe_q) begin
			rfsh_count <= rfsh_count + 1'b1;
		end
	end

	// snapshot on falling refresh enable so the address stays put
	always_ff @(posedge clk) begin
		if (rst) begin
			rfsh_hold <= `RFSH_RESET;
		end else if (!bus.refresh_enable_n && rfsh_en_q) begin
			rfsh_hold <= rfsh_count;
		end
	end

	assign bus.refresh_count_msb = rfsh_count[`RFSH_W-1];

	////////////////////////////////////////////////////////////////
	// ownership decode; refresh beats dma if both are low
	always_comb begin
		if (!bus.hold_ack) begin
			owner = own_cpu;
		end else if (!bus.refresh_enable_n) begin
			owner = own_rfsh;
		end else if (!bus.dma_addr_en_n) begin
			owner = own_dma;
		end else begin
			owner = own_hold;
		end
	end

	////////////////////////////////////////////////////////////////
	// system bus drive; bit zero only during refresh
	always_comb begin
		bus.system_addr_out = '0;
		bus.system_addr_oe = '0;
		bus.sys_upper_byte_n_out = upper_latch;
		bus.sys_upper_byte_n_oe = 1'b0;
		case (owner)
			own_cpu: begin
				bus.system_addr_out = {cur_sys, 1'b0};
				bus.system_addr_oe = {{`CPU_ADDR_W{1'b1}}, 1'b0};
				bus.sys_upper_byte_n_out = bus.addr_latch_en ? bus.cpu_upper_byte_n
					: upper_latch;
				bus.sys_upper_byte_n_oe = 1'b1;
			end
			own_dma: begin
				bus.system_addr_out = {cur_sys, 1'b0};
				bus.system_addr_oe = {{`CPU_ADDR_W{1'b1}}, 1'b0};
			end
			own_rfsh: begin
				bus.system_addr_out = {{(`SYS_ADDR_W-`RFSH_W){1'b0}}, rfsh_hold};
				bus.system_addr_oe = '1;
			end
			own_hold: begin
				bus.system_addr_oe = '0;
			end
			default: begin
				bus.system_addr_oe = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// peripheral bus: input during dma, else driven
	always_comb begin
		bus.periph_addr_oe = (owner != own_dma);
		bus.periph_upper_byte_n_oe = (owner != own_dma);
		if (owner == own_hold) begin
			// slot master drives system bus; pass it through
			bus.periph_addr_out = bus.system_addr_in[`CPU_ADDR_W:1];
			bus.periph_upper_byte_n_out = bus.sys_upper_byte_n_in;
		end else begin
			bus.periph_addr_out = cur_sys;
			bus.periph_upper_byte_n_out = bus.addr_latch_en ? bus.cpu_upper_byte_n
				: upper_latch;
		end
	end

	////////////////////////////////////////////////////////////////
	// dram mux source: cpu when owning, else system bus
	always_comb begin
		if (!bus.hold_ack) begin
			mux_src = cur_dram;
		end else if (owner == own_dma) begin
			mux_src = bus.system_addr_in[`CPU_ADDR_W:1];
		end else begin
			mux_src = bus.system_addr_in[`CPU_ADDR_W:1];
		end
	end

	// half select, with refresh address taking over during refresh
	always_comb begin
		if (owner == own_rfsh) begin
			next_dram_addr = bus.row_col_select ? '0
				: {rfsh_hold[0], rfsh_hold[`DRAM_ADDR_W-1:1]};
		end else if (bus.row_col_select) begin
			next_dram_addr = mux_src[`CPU_ADDR_W-1:`DRAM_HALF];
		end else begin
			next_dram_addr = mux_src[`DRAM_HALF-1:0];
		end
	end

	// registered dram output keeps the bus glitch free
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.dram_addr <= '0;
		end else begin
			bus.dram_addr <= next_dram_addr;
		end
	end

endmodule // addr_buf_dev

// ==== addr_buf_ctl.sv ====
`timescale 1ns/100ps
`include "addr_buf_regs.svh"
module addr_buf_ctl (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// user side
	input wire logic early_latch_mode,
	input wire logic mem_read_cmd_n,
	input wire logic mem_write_cmd_n,
	input wire logic cycle_start,
	input wire logic halt_cycle,
	input wire logic [`CPU_ADDR_W-1:0] user_addr,
	input wire logic user_upper_byte_n,
	input wire logic user_hold_ack,
	input wire logic dma_active,
	input wire logic refresh_needed,
	input wire logic refresh_strobe,
	input wire logic user_row_col_select,
	// link
	addr_buf_if.ctl bus
);

	////////////////////////////////////////////////////////////////
	logic ale_q; // one-cycle latch pulse

	// latch pulse per bus cycle, never for halt
	always_ff @(posedge clk) begin
		if (rst) begin
			ale_q <= 1'b0;
		end else begin
			ale_q <= cycle_start && !halt_cycle;
		end
	end

	// row latch early with command in fast mode, else equal to ale
	assign bus.addr_latch_en = ale_q;
	assign bus.dram_row_latch_en = early_latch_mode
		? (ale_q || !mem_read_cmd_n || !mem_write_cmd_n) : ale_q;

	// plain pass of the remaining controls, the three requests inverted to low-active
	assign bus.cpu_addr = user_addr;
	assign bus.cpu_upper_byte_n = user_upper_byte_n;
	assign bus.hold_ack = user_hold_ack;
	assign bus.dma_addr_en_n = !dma_active;
	assign bus.refresh_enable_n = !refresh_needed;
	assign bus.rfsh_cycle_n = !refresh_strobe;
	assign bus.row_col_select = user_row_col_select;

endmodule // addr_buf_ctl

// ==== addr_buf_asserts.sv ====
`timescale 1ns/100ps
`include "addr_buf_regs.svh"
module addr_buf_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// processor side controls
	input wire logic [`CPU_ADDR_W-1:0] cpu_addr,
	input wire logic addr_latch_en,
	input wire logic dram_row_latch_en,
	input wire logic hold_ack,
	input wire logic dma_addr_en_n,
	input wire logic refresh_enable_n,
	input wire logic row_col_select,
	// device outputs
	input wire logic [`SYS_ADDR_W-1:0] system_addr_out,
	input wire logic [`SYS_ADDR_W-1:0] system_addr_oe,
	input wire logic sys_upper_byte_n_oe,
	input wire logic [`CPU_ADDR_W-1:0] periph_addr_out,
	input wire logic periph_addr_oe,
	input wire logic periph_upper_byte_n_oe,
	input wire logic [`DRAM_ADDR_W-1:0] dram_addr,
	input wire logic refresh_count_msb
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// refresh owns the bus only once the processor has let go
	wire rf = hold_ack && !refresh_enable_n;
	wire [7:0] lo = cpu_addr[7:0];
	wire [7:0] hi = cpu_addr[15:8];
	////////////////////////////////////////////////////////////////////////////////
	AST_SA0_REFRESH_ONLY: assert property (system_addr_oe[0] == rf)
		else $error("bit zero enable wrong");
	AST_SYS_UPPER_BYTE_N_INPUT_IN_HOLD: assert property (hold_ack && dma_addr_en_n |-> !sys_upper_byte_n_oe)
		else $error("byte high driven in hold");
	AST_CPU_TRANSPARENT: assert property (!hold_ack && addr_latch_en |->
		periph_addr_out == cpu_addr && system_addr_out[16:1] == cpu_addr)
		else $error("open latch not transparent");
	AST_CPU_DRIVES: assert property (!hold_ack |->
		periph_addr_oe && system_addr_oe == 17'h1_fffe && sys_upper_byte_n_oe)
		else $error("cpu mode enables wrong");
	// a closed latch must not drift, the classic slip being a lost enable term
	AST_LATCH_HOLDS: assert property (!hold_ack && !$past(hold_ack) && !$past(rst)
		&& !addr_latch_en |-> $stable(periph_addr_out))
		else $error("closed latch moved");
	AST_DMA_PERIPH_INPUT: assert property (hold_ack && !dma_addr_en_n && refresh_enable_n
		|-> !periph_addr_oe && !periph_upper_byte_n_oe)
		else $error("periph driven in dma");
	AST_REFRESH_UPPER_ZERO: assert property (rf |->
		system_addr_out[16:9] == 8'h00 && &system_addr_oe)
		else $error("refresh upper bits wrong");
	AST_DRAM_ROW_HALF: assert property (!hold_ack && dram_row_latch_en && !row_col_select
		|=> dram_addr == $past(lo))
		else $error("dram low half wrong");
	AST_DRAM_COL_HALF: assert property (!hold_ack && dram_row_latch_en && row_col_select
		|=> dram_addr == $past(hi))
		else $error("dram high half wrong");
	AST_COUNT_CLEARED: assert property ($past(rst) |-> !refresh_count_msb)
		else $error("counter not cleared");
	// main scenarios reached
	cover property (rf);
	cover property (hold_ack && !dma_addr_en_n);
	cover property (!hold_ack && addr_latch_en);
endmodule // addr_buf_asserts

// ==== address_buffer_refresh_tb.sv ====
`timescale 1ns/100ps
`include "addr_buf_regs.svh"
module address_buffer_refresh_tb;
	logic clk = 0, rst = 1;
	// user side of the controller
	logic elm = 0, rd_n = 1, wr_n = 1, cs = 0, halt = 0, ub = 1, ha = 0, dma = 0;
	logic rn = 0, rs = 0, rcs = 0, lb = 1;
	logic [15:0] ua = 16'h0000, la = 16'h0000, hs = 16'h0000;
	// far parties on the two-way buses
	logic [16:0] ext_sa = 17'h0_0000;
	logic [15:0] ext_xa = 16'h0000;
	logic [8:0] m_cnt = 9'h000;
	logic [31:0] seed = 32'h0000_0042, r;
	int err_count = 0, n_tests = 0, cyc = 0;
	addr_buf_if b();
	// wire level from every driver's enable
	assign b.system_addr_in = (b.system_addr_out & b.system_addr_oe) | (ext_sa & ~b.system_addr_oe);
	assign b.periph_addr_in = b.periph_addr_oe ? b.periph_addr_out : ext_xa;
	assign b.sys_upper_byte_n_in = b.sys_upper_byte_n_oe ? b.sys_upper_byte_n_out : ext_sa[0];
	assign b.periph_upper_byte_n_in = b.periph_upper_byte_n_oe ? b.periph_upper_byte_n_out : ext_xa[0];
	addr_buf_dev addr_buf_dev_inst (.clk(clk), .rst(rst), .bus(b));
	addr_buf_ctl addr_buf_ctl_inst (.clk(clk), .rst(rst), .early_latch_mode(elm),
		.mem_read_cmd_n(rd_n), .mem_write_cmd_n(wr_n), .cycle_start(cs), .halt_cycle(halt),
		.user_addr(ua), .user_upper_byte_n(ub), .user_hold_ack(ha), .dma_active(dma),
		.refresh_needed(rn), .refresh_strobe(rs), .user_row_col_select(rcs), .bus(b));
	addr_buf_asserts addr_buf_asserts_inst (.clk(clk), .rst(rst), .cpu_addr(b.cpu_addr),
		.addr_latch_en(b.addr_latch_en), .dram_row_latch_en(b.dram_row_latch_en),
		.hold_ack(b.hold_ack), .dma_addr_en_n(b.dma_addr_en_n),
		.refresh_enable_n(b.refresh_enable_n), .row_col_select(b.row_col_select),
		.system_addr_out(b.system_addr_out), .system_addr_oe(b.system_addr_oe),
		.sys_upper_byte_n_oe(b.sys_upper_byte_n_oe), .periph_addr_out(b.periph_addr_out),
		.periph_addr_oe(b.periph_addr_oe), .periph_upper_byte_n_oe(b.periph_upper_byte_n_oe),
		.dram_addr(b.dram_addr), .refresh_count_msb(b.refresh_count_msb));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string nm, logic [16:0] e, logic [16:0] s);
		n_tests++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			err_count++;
		end
	endtask
	// inputs only ever move on the falling edge
	task automatic w(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// hang guard, well above the ~3300 cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		w(16);
		rst = 0;
		w(2);
		// processor cycles, every fourth a halt that must not relatch
		for (int i = 0; i < 40; i++) begin
			r = xs();
			ua = r[15:0];
			ub = r[16];
			rcs = r[17];
			halt = (i % 4 == 3);
			cs = 1;
			w(1);
			cs = 0;
			w(3);
			if (!halt) la = ua;
			if (!halt) lb = ub;
			ua = r[31:16];
			w(2);
			chk("periph addr", {1'b0, la}, {1'b0, b.periph_addr_out});
			chk("system addr", {1'b0, la}, {1'b0, b.system_addr_out[16:1]});
			chk("periph byte high", lb, b.periph_upper_byte_n_out);
			chk("system byte high", lb, b.sys_upper_byte_n_out);
			repeat (2) begin
				chk("dram addr", rcs ? la[15:8] : la[7:0], b.dram_addr);
				rcs = ~rcs;
				w(2);
			end
		end
		// early mode: a command alone opens the dram latch, ale stays low
		elm = 1;
		for (int i = 0; i < 2; i++) begin
			r = xs();
			ua = r[15:0];
			rcs = 0;
			rd_n = (i == 1);
			wr_n = (i == 0);
			w(1);
			rd_n = 1;
			wr_n = 1;
			ua = r[31:16];
			w(2);
			chk("early periph", {1'b0, la}, {1'b0, b.periph_addr_out});
			chk("early dram lo", r[7:0], b.dram_addr);
			rcs = 1;
			w(2);
			chk("early dram hi", r[15:8], b.dram_addr);
		end
		elm = 0;
		// plain hold and dma, picked at random
		ha = 1;
		for (int i = 0; i < 8; i++) begin
			r = xs();
			ext_sa = r[16:0];
			dma = r[17];
			rcs = r[18];
			w(3);
			hs = dma ? la : ext_sa[16:1];
			chk("hold dram", rcs ? hs[15:8] : hs[7:0], b.dram_addr);
			if (!dma) chk("hold periph", {1'b0, ext_sa[16:1]}, {1'b0, b.periph_addr_out});
			if (dma) chk("dma system", {1'b0, la}, {1'b0, b.system_addr_out[16:1]});
		end
		dma = 0;
		// enough refreshes to carry the counter into its top bit
		for (int i = 0; i < 260; i++) begin
			r = xs();
			rcs = r[0];
			rn = 1;
			w(3);
			chk("refresh sa", {8'h00, m_cnt}, b.system_addr_out);
			chk("refresh ma", rcs ? 8'h00 : {m_cnt[0], m_cnt[7:1]}, b.dram_addr);
			chk("count msb", m_cnt[8], b.refresh_count_msb);
			rs = 1;
			w(2);
			rs = 0;
			m_cnt++;
			w(3);
			rn = 0;
			w(3);
		end
		// mid-run reset must bring the counter back to row zero
		rst = 1;
		w(2);
		rst = 0;
		m_cnt = 9'h000;
		w(2);
		rn = 1;
		w(3);
		chk("reset msb", m_cnt[8], b.refresh_count_msb);
		chk("reset refresh sa", {8'h00, m_cnt}, b.system_addr_out);
		rn = 0;
		w(2);
		test_done();
	end
endmodule // address_buffer_refresh_tb
